/* File: cafit_regs.vh */
`ifndef CAFIT_REGS_VH
`define CAFIT_REGS_VH

// ----------------------------------------
// operations
// ----------------------------------------
`define CAFIT_OP_NONE      3'h0
`define CAFIT_OP_COND_ALU  3'h1
`define CAFIT_OP_TRAP      3'h2
`define CAFIT_OP_INC       3'h3
`define CAFIT_OP_INSERT    3'h4

// ----------------------------------------
// condition code bit positions
// ----------------------------------------
`define CAFIT_CC_C 0
`define CAFIT_CC_V 1
`define CAFIT_CC_Z 2
`define CAFIT_CC_N 3
`define CAFIT_CC_U 4
`define CAFIT_CC_E 5
`define CAFIT_CC_L 6
`define CAFIT_CC_S 7

// ----------------------------------------
// control word fields
// ----------------------------------------
`define CAFIT_OFS_LO      0
`define CAFIT_WID_LO      12
`define CAFIT_OFS16_LO    8
`define CAFIT_WID16_LO    16
`define CAFIT_FIELD_BITS  6
`define CAFIT_ACC_BITS    56

// ----------------------------------------
// operand selects
// ----------------------------------------
`define CAFIT_SEL_X0 3'h0
`define CAFIT_SEL_X1 3'h1
`define CAFIT_SEL_Y0 3'h2
`define CAFIT_SEL_Y1 3'h3
`define CAFIT_SEL_AW 3'h4
`define CAFIT_SEL_BW 3'h5

// ----------------------------------------
// exception and reset values
// ----------------------------------------
`define CAFIT_ILL_VECTOR  24'h00003e
`define CAFIT_TRAP_LEVEL  2'h3
`define CAFIT_CCR_RESET   8'h00
`define CAFIT_RET_SKIP    24'h000002

`endif

/* File: cafit_flag_gen.v */
`default_nettype none
`include "cafit_regs.vh"

module cafit_flag_gen
(
  // result under test
  input  wire [55:0] result_i,
  input  wire        scale_mode_i,
  // derived flags
  output wire        ext_flag_o,
  output wire        unnorm_flag_o,
  output wire        neg_flag_o,
  output wire        zero_flag_o
);

  // ----------------------------------------
  // standard flag definitions
  // ----------------------------------------
  // extension in use when bits 55..47 are not all equal
  assign ext_flag_o    = ~((&result_i[55:47]) | ~(|result_i[55:47]));
  // unnormalized when the two bits under the integer point match and scale mode is off
  assign unnorm_flag_o = ~(result_i[47] ^ result_i[46]) & ~scale_mode_i;
  assign neg_flag_o    = result_i[55];
  assign zero_flag_o   = ~(|result_i);

endmodule

`default_nettype wire

/* File: cafit_core.v */
`default_nettype none
`include "cafit_regs.vh"

module cafit_core
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // decoded instruction
  input  wire        issue_i,
  input  wire [2:0]  op_i,
  input  wire        cond_true_i,
  input  wire        dest_b_i,
  input  wire [2:0]  src_sel_i,
  input  wire [2:0]  ctl_sel_i,
  input  wire        ctl_imm_i,
  input  wire [23:0] immediate_control_word_i,
  input  wire [23:0] trap_pc_i,
  // parallel ALU result for the conditional prefix
  input  wire [55:0] alu_result_i,
  input  wire [7:0]  alu_ccr_i,
  // data registers
  input  wire [23:0] x0_i,
  input  wire [23:0] x1_i,
  input  wire [23:0] y0_i,
  input  wire [23:0] y1_i,
  // mode and loop context
  input  wire        sixteen_bit_mode_i,
  input  wire        scale_mode_i,
  input  wire        long_isr_i,
  input  wire        single_instr_loop_busy_i,
  input  wire        at_loop_end_addr_i,
  input  wire        prev_interrupted_i,
  input  wire        return_i,
  input  wire [15:0] loop_count_reg_i,
  input  wire        loop_count_load_i,
  // architectural state
  output reg  [55:0] acc_a_o,
  output reg  [55:0] acc_b_o,
  output reg  [7:0]  condition_code_register_o,
  output reg  [1:0]  irq_mask_bits_o,
  output reg  [15:0] loop_count_reg_o,
  // exception
  output reg         exc_pending_o,
  output reg         vector_fetch_o,
  output reg  [23:0] vector_addr_o,
  output reg  [23:0] return_addr_o,
  output reg         resume_o,
  output reg  [23:0] resume_addr_o,
  output wire        busy_o
);

  // ----------------------------------------
  // trap sequencer states
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_VEC  = 2'h2;
  localparam ST_SVC  = 2'h3;

  reg [1:0] state;
  reg [1:0] next_state;

  // ----------------------------------------
  // operand selection
  // ----------------------------------------
  reg  [55:0] dest_old;
  reg  [23:0] src_bits;
  reg  [23:0] ctl_reg;
  wire [23:0] ctl_word;

  always @*
  begin
    dest_old = dest_b_i ? acc_b_o : acc_a_o;
    case (src_sel_i)
      `CAFIT_SEL_X0: src_bits = x0_i;
      `CAFIT_SEL_X1: src_bits = x1_i;
      `CAFIT_SEL_Y0: src_bits = y0_i;
      `CAFIT_SEL_Y1: src_bits = y1_i;
      `CAFIT_SEL_AW: src_bits = acc_a_o[23:0];
      `CAFIT_SEL_BW: src_bits = acc_b_o[23:0];
      default:       src_bits = 24'h000000;
    endcase
    case (ctl_sel_i)
      `CAFIT_SEL_X0: ctl_reg = x0_i;
      `CAFIT_SEL_X1: ctl_reg = x1_i;
      `CAFIT_SEL_Y0: ctl_reg = y0_i;
      `CAFIT_SEL_Y1: ctl_reg = y1_i;
      `CAFIT_SEL_AW: ctl_reg = acc_a_o[47:24];
      `CAFIT_SEL_BW: ctl_reg = acc_b_o[47:24];
      default:       ctl_reg = 24'h000000;
    endcase
  end

  assign ctl_word = ctl_imm_i ? immediate_control_word_i : ctl_reg;

  // ----------------------------------------
  // field insert
  // ----------------------------------------
  wire [5:0] ins_width;
  wire [5:0] ins_offset;

  assign ins_width  = sixteen_bit_mode_i ?
                      ctl_word[`CAFIT_WID16_LO +: `CAFIT_FIELD_BITS] :
                      ctl_word[`CAFIT_WID_LO +: `CAFIT_FIELD_BITS];
  assign ins_offset = sixteen_bit_mode_i ?
                      ctl_word[`CAFIT_OFS16_LO +: `CAFIT_FIELD_BITS] :
                      ctl_word[`CAFIT_OFS_LO +: `CAFIT_FIELD_BITS];

  // shifts past bit 55 drop out; undefined region above 56 left to fall as it may
  wire [55:0] field_ones;
  wire [55:0] field_mask;
  wire [55:0] field_data;
  wire [55:0] ins_result;

  assign field_ones = ~({56{1'b1}} << ins_width);
  assign field_mask = field_ones << ins_offset;
  assign field_data = ({32'h00000000, src_bits} & field_ones) << ins_offset;
  assign ins_result = (dest_old & ~field_mask) | (field_data & field_mask);

  // ----------------------------------------
  // increment
  // ----------------------------------------
  wire [56:0] inc_sum;
  wire [55:0] inc_result;
  wire        inc_ovf;

  assign inc_sum    = {1'b0, dest_old} + 57'h000000000000001;
  assign inc_result = inc_sum[55:0];
  assign inc_ovf    = ~dest_old[55] & inc_result[55];

  // ----------------------------------------
  // flag generation
  // ----------------------------------------
  wire [55:0] flag_src;
  wire        f_e;
  wire        f_u;
  wire        f_n;
  wire        f_z;

  assign flag_src = (op_i == `CAFIT_OP_INC) ? inc_result : ins_result;

  cafit_flag_gen u_flags
  (
    .result_i      (flag_src),
    .scale_mode_i  (scale_mode_i),
    .ext_flag_o    (f_e),
    .unnorm_flag_o (f_u),
    .neg_flag_o    (f_n),
    .zero_flag_o   (f_z)
  );

  // ----------------------------------------
  // execute
  // ----------------------------------------
  reg [55:0] next_acc;
  reg        acc_we;
  reg [7:0]  next_ccr;
  reg        trap_take;

  always @*
  begin
    next_acc  = dest_old;
    acc_we    = 1'b0;
    next_ccr  = condition_code_register_o;
    trap_take = 1'b0;
    if (issue_i && state == ST_IDLE)
    begin
      case (op_i)
        `CAFIT_OP_COND_ALU:
        begin
          // false condition leaves everything alone
          if (cond_true_i)
          begin
            next_acc = alu_result_i;
            acc_we   = 1'b1;
            next_ccr = alu_ccr_i;
          end
        end
        `CAFIT_OP_TRAP:
        begin
          trap_take = 1'b1;
        end
        `CAFIT_OP_INC:
        begin
          next_acc = inc_result;
          acc_we   = 1'b1;
          next_ccr[`CAFIT_CC_L] = condition_code_register_o[`CAFIT_CC_L] | inc_ovf;
          next_ccr[`CAFIT_CC_E] = f_e;
          next_ccr[`CAFIT_CC_U] = f_u;
          next_ccr[`CAFIT_CC_N] = f_n;
          next_ccr[`CAFIT_CC_Z] = f_z;
          next_ccr[`CAFIT_CC_V] = inc_ovf;
          next_ccr[`CAFIT_CC_C] = inc_sum[56];
        end
        `CAFIT_OP_INSERT:
        begin
          next_acc = ins_result;
          acc_we   = 1'b1;
          next_ccr[`CAFIT_CC_E] = f_e;
          next_ccr[`CAFIT_CC_U] = f_u;
          next_ccr[`CAFIT_CC_N] = f_n;
          next_ccr[`CAFIT_CC_Z] = f_z;
          next_ccr[`CAFIT_CC_V] = 1'b0;
          next_ccr[`CAFIT_CC_C] = 1'b0;
        end
        default:
        begin
          acc_we = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // trap sequencer
  // ----------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE: if (trap_take) next_state = ST_WAIT;
      // repeat cannot be interrupted, so hold off until it ends
      ST_WAIT: if (!single_instr_loop_busy_i) next_state = ST_VEC;
      ST_VEC:  next_state = ST_SVC;
      ST_SVC:  if (return_i) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  assign busy_o = (state != ST_IDLE);

  // ----------------------------------------
  // sequencer register
  // ----------------------------------------
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ----------------------------------------
  // accumulators and condition codes
  // ----------------------------------------
  // refused or false-condition issues leave acc_we low and next_ccr at the old value
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_a_o                   <= 56'h00000000000000;
      acc_b_o                   <= 56'h00000000000000;
      condition_code_register_o <= `CAFIT_CCR_RESET;
    end
    else
    begin
      condition_code_register_o <= next_ccr;
      if (acc_we && !dest_b_i)
        acc_a_o <= next_acc;
      if (acc_we && dest_b_i)
        acc_b_o <= next_acc;
    end
  end

  // ----------------------------------------
  // exception entry
  // ----------------------------------------
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      exc_pending_o   <= 1'b0;
      vector_fetch_o  <= 1'b0;
      vector_addr_o   <= 24'h000000;
      return_addr_o   <= 24'h000000;
      irq_mask_bits_o <= 2'h0;
    end
    else
    begin
      vector_fetch_o <= 1'b0;
      if (trap_take)
      begin
        exc_pending_o <= 1'b1;
        return_addr_o <= trap_pc_i + `CAFIT_RET_SKIP;
      end
      if (state == ST_VEC)
      begin
        exc_pending_o  <= 1'b0;
        vector_fetch_o <= 1'b1;
        vector_addr_o  <= `CAFIT_ILL_VECTOR;
        // short service routines keep the current mask level
        if (long_isr_i)
          irq_mask_bits_o <= `CAFIT_TRAP_LEVEL;
      end
    end
  end

  // ----------------------------------------
  // return from service
  // ----------------------------------------
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      resume_o      <= 1'b0;
      resume_addr_o <= 24'h000000;
    end
    else
    begin
      resume_o <= 1'b0;
      if (state == ST_SVC && return_i)
      begin
        resume_o      <= 1'b1;
        resume_addr_o <= return_addr_o;
      end
    end
  end

  // ----------------------------------------
  // loop counter
  // ----------------------------------------
  reg [15:0] next_loop_count;

  // same loop-end mechanism as restricted instructions: two decrements
  // an explicit load from the loop unit wins over the double step
  always @*
  begin
    next_loop_count = loop_count_reg_o;
    if (loop_count_load_i)
      next_loop_count = loop_count_reg_i;
    else if (trap_take && at_loop_end_addr_i && prev_interrupted_i)
      next_loop_count = loop_count_reg_o - 16'h0002;
  end

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      loop_count_reg_o <= 16'h0000;
    else
      loop_count_reg_o <= next_loop_count;
  end

endmodule

`default_nettype wire

/* File: cafit_core_properties.sv */
`default_nettype none
`include "cafit_regs.vh"
module cafit_core_props
(
  // watched ports
  input wire logic        clk_i, rst_n_i, issue_i, cond_true_i, dest_b_i, busy_o,
  input wire logic        single_instr_loop_busy_i, vector_fetch_o, resume_o,
  input wire logic [2:0]  op_i,
  input wire logic [7:0]  alu_ccr_i, condition_code_register_o,
  input wire logic [23:0] trap_pc_i, vector_addr_o, return_addr_o, resume_addr_o,
  input wire logic [55:0] acc_a_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire take      = issue_i && !busy_o;
  wire take_alu  = take && op_i == `CAFIT_OP_COND_ALU;
  wire take_trap = take && op_i == `CAFIT_OP_TRAP;
  wire take_inc  = take && op_i == `CAFIT_OP_INC && !dest_b_i;
  wire take_ins  = take && op_i == `CAFIT_OP_INSERT;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  cond_true_a: assert property (
    take_alu && cond_true_i |=> condition_code_register_o == $past(alu_ccr_i))
    else $error("true condition did not load flags");
  cond_false_a: assert property (
    take_alu && !cond_true_i |=> $stable(condition_code_register_o) && $stable(acc_a_o))
    else $error("false condition changed state");
  trap_flags_a: assert property (
    take_trap |=> $stable(condition_code_register_o))
    else $error("trap changed flags");
  trap_vector_a: assert property (
    take_trap && !single_instr_loop_busy_i |-> ##[2:3] vector_fetch_o)
    else $error("trap vector fetch missing");
  vector_addr_a: assert property (
    vector_fetch_o |-> vector_addr_o == `CAFIT_ILL_VECTOR)
    else $error("wrong vector address");
  repeat_hold_a: assert property (
    single_instr_loop_busy_i |=> !vector_fetch_o)
    else $error("vector fetch during repeat");
  return_addr_a: assert property (
    take_trap |=> return_addr_o == $past(trap_pc_i) + `CAFIT_RET_SKIP)
    else $error("wrong return address");
  resume_addr_a: assert property (
    resume_o |-> resume_addr_o == return_addr_o)
    else $error("wrong resume address");
  inc_sum_a: assert property (
    take_inc |=> acc_a_o == $past(acc_a_o) + 56'h1 && $stable(condition_code_register_o[7]))
    else $error("increment wrong");
  insert_flags_a: assert property (
    take_ins |=> condition_code_register_o[1:0] == 2'h0
      && $stable(condition_code_register_o[7:6]))
    else $error("insert flags wrong");
  trap_seen_c: cover property (take_trap);
  insert_seen_c: cover property (take_ins);
  resume_seen_c: cover property (resume_o);
endmodule
`default_nettype wire

/* File: cafit_core_tb.sv */
`default_nettype none
`include "cafit_regs.vh"
module cafit_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_n_i = 0, issue_i = 0, cond_true_i = 0, dest_b_i = 0, ctl_imm_i = 0;
  logic sixteen_bit_mode_i = 0, scale_mode_i = 0, long_isr_i = 0, return_i = 0;
  logic single_instr_loop_busy_i = 0, at_loop_end_addr_i = 0, prev_interrupted_i = 0;
  logic loop_count_load_i = 0;
  logic [2:0]  op_i = 3'h0, src_sel_i = 3'h0, ctl_sel_i = 3'h0;
  logic [7:0]  alu_ccr_i = 8'h00;
  logic [15:0] loop_count_reg_i = 16'h0000;
  logic [23:0] immediate_control_word_i = 0, trap_pc_i = 0, x0_i = 0, x1_i = 0, y0_i = 0, y1_i = 0;
  logic [55:0] alu_result_i = 56'h0;
  wire  [55:0] acc_a_o, acc_b_o;
  wire  [23:0] vector_addr_o, return_addr_o, resume_addr_o;
  wire  [15:0] loop_count_reg_o;
  wire  [7:0]  condition_code_register;
  wire  [1:0]  irq_mask_bits_o;
  wire         exc_pending_o, vector_fetch_o, resume_o, busy_o;
  int          bad_count = 0, total_checks = 0;
  logic [63:0] seed = 64'd43161;
  cafit_core i_cafit_core (.clk_i, .rst_n_i, .issue_i, .op_i, .cond_true_i, .dest_b_i,
    .src_sel_i, .ctl_sel_i, .ctl_imm_i, .immediate_control_word_i, .trap_pc_i, .alu_result_i,
    .alu_ccr_i, .x0_i, .x1_i, .y0_i, .y1_i, .sixteen_bit_mode_i, .scale_mode_i, .long_isr_i,
    .single_instr_loop_busy_i, .at_loop_end_addr_i, .prev_interrupted_i, .return_i,
    .loop_count_reg_i, .loop_count_load_i, .acc_a_o, .acc_b_o, .condition_code_register_o(condition_code_register),
    .irq_mask_bits_o, .loop_count_reg_o, .exc_pending_o, .vector_fetch_o, .vector_addr_o,
    .return_addr_o, .resume_o, .resume_addr_o, .busy_o);
  always #5 clk_i = ~clk_i;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [63:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed;
  endfunction
  // flags E U N Z; scaling forces U low
  function automatic logic [3:0] flg(input logic [55:0] r, input logic sc);
    return {!(&r[55:47] || !(|r[55:47])), !(r[47] ^ r[46]) && !sc, r[55], r == 56'h0};
  endfunction
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic go(input logic [2:0] op);
    @(posedge clk_i);
    issue_i <= 1'b1;
    op_i <= op;
    @(posedge clk_i);
    issue_i <= 1'b0;
    #1;
  endtask
  task automatic trap(input int single_instr_loop, input logic lctx, input logic lng);
    logic [63:0] t;
    logic [55:0] a;
    logic [7:0]  cc;
    logic [15:0] lc;
    logic [1:0]  mk;
    int          n;
    t = rnd();
    a = acc_a_o;
    cc = condition_code_register;
    lc = loop_count_reg_o;
    mk = irq_mask_bits_o;
    trap_pc_i <= t[23:0];
    long_isr_i <= lng;
    dest_b_i <= 1'b0;
    single_instr_loop_busy_i <= single_instr_loop > 0;
    at_loop_end_addr_i <= lctx;
    prev_interrupted_i <= lctx & lng;
    go(`CAFIT_OP_TRAP);
    chk("pending", {exc_pending_o, busy_o}, 2'b11);
    chk("return addr", return_addr_o, 24'(t[23:0] + 24'h2));
    chk("loop count", loop_count_reg_o, lctx & lng ? lc - 16'h2 : lc);
    // the repeat holds the exception back until it ends
    for (n = 0; n < single_instr_loop; n++)
    begin
      chk("early vector", vector_fetch_o, 1'b0);
      @(posedge clk_i);
      #1;
    end
    single_instr_loop_busy_i <= 1'b0;
    for (n = 0; n < 8 && vector_fetch_o !== 1'b1; n++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk("vector fetch", vector_fetch_o, 1'b1);
    chk("vector addr", vector_addr_o, `CAFIT_ILL_VECTOR);
    chk("pending clear", exc_pending_o, 1'b0);
    chk("irq mask", irq_mask_bits_o, lng ? `CAFIT_TRAP_LEVEL : mk);
    go(`CAFIT_OP_INC);
    chk("refused inc", acc_a_o, a);
    chk("trap ccr", condition_code_register, cc);
    @(posedge clk_i);
    return_i <= 1'b1;
    @(posedge clk_i);
    return_i <= 1'b0;
    #1;
    chk("resume", {resume_o, busy_o}, 2'b10);
    chk("resume addr", resume_addr_o, 24'(t[23:0] + 24'h2));
    $display("trap test done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #50us;
    bad_count++;
    wrap_up();
  end
  initial
  begin
    logic [63:0] t, u, v;
    logic [55:0] old, r, m;
    logic [23:0] cw;
    logic [23:0] rg [0:5];
    logic [7:0]  cc;
    logic [2:0]  s;
    logic [2:0]  ctl;
    int          w, o;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (24)
    begin
      t = rnd();
      old = acc_a_o;
      cc = condition_code_register;
      dest_b_i <= 1'b0;
      cond_true_i <= t[60];
      alu_result_i <= t[55:0];
      alu_ccr_i <= t[63:56];
      go(`CAFIT_OP_COND_ALU);
      chk("cond acc", acc_a_o, t[60] ? t[55:0] : old);
      chk("cond ccr", condition_code_register, t[60] ? t[63:56] : cc);
    end
    $display("conditional test done");
    for (int i = 0; i < 6; i++)
    begin
      t = rnd();
      v = (i == 0) ? 56'h7fffffffffffff : (i == 1) ? 56'hffffffffffffff : t[55:0];
      alu_result_i <= v[55:0];
      alu_ccr_i <= t[63:56];
      cond_true_i <= 1'b1;
      dest_b_i <= t[0];
      scale_mode_i <= t[1];
      go(`CAFIT_OP_COND_ALU);
      r = v[55:0] + 56'h1;
      go(`CAFIT_OP_INC);
      chk("inc acc", t[0] ? acc_b_o : acc_a_o, r);
      chk("inc ccr", condition_code_register, {t[63], t[62] | (i == 0), flg(r, t[1]), i == 0, i == 1});
    end
    $display("increment test done");
    repeat (40)
    begin
      t = rnd();
      u = rnd();
      v = rnd();
      w = int'(t[6:2]) % (t[1] ? 17 : 25);
      o = t[1] ? 16 + int'(t[13:8]) % (41 - w) : int'(t[13:8]) % (57 - w);
      cw = t[1] ? {u[23:22], 6'(w), u[15:14], 6'(o), u[7:0]} : {u[23:18], 6'(w), u[11:6], 6'(o)};
      ctl = t[17:15] % 3'd6;
      // upper-word control: preload that accumulator so its middle word is the control word
      if (ctl > 3'd3)
      begin
        alu_result_i <= {u[31:24], cw, u[47:24]};
        alu_ccr_i <= u[55:48];
        cond_true_i <= 1'b1;
        dest_b_i <= ctl[0];
        go(`CAFIT_OP_COND_ALU);
      end
      rg[0] = v[23:0];
      rg[1] = v[47:24];
      rg[2] = {v[63:48], u[63:56]};
      rg[3] = t[63:40];
      rg[4] = acc_a_o[23:0];
      rg[5] = acc_b_o[23:0];
      if (!t[14] && ctl < 3'd4)
        rg[ctl] = cw;
      s = t[20:18] % 3'd6;
      old = t[21] ? acc_b_o : acc_a_o;
      cc = condition_code_register;
      m = ((56'h1 << w) - 56'h1) << o;
      r = (old & ~m) | ((56'(rg[s]) << o) & m);
      {x0_i, x1_i, y0_i, y1_i} <= {rg[0], rg[1], rg[2], rg[3]};
      immediate_control_word_i <= cw;
      ctl_imm_i <= t[14];
      ctl_sel_i <= ctl;
      src_sel_i <= s;
      dest_b_i <= t[21];
      sixteen_bit_mode_i <= t[1];
      scale_mode_i <= t[22];
      go(`CAFIT_OP_INSERT);
      chk("insert acc", t[21] ? acc_b_o : acc_a_o, r);
      chk("insert ccr", condition_code_register, {cc[7:6], flg(r, t[22]), 2'b00});
    end
    $display("insert test done");
    @(posedge clk_i);
    loop_count_reg_i <= 16'h0010;
    loop_count_load_i <= 1'b1;
    @(posedge clk_i);
    loop_count_load_i <= 1'b0;
    #1;
    trap(0, 1'b0, 1'b1);
    trap(0, 1'b1, 1'b0);
    trap(4, 1'b1, 1'b1);
    wrap_up();
  end
endmodule
bind cafit_core cafit_core_props i_cafit_core_props (.clk_i, .rst_n_i, .issue_i, .cond_true_i,
  .dest_b_i, .busy_o, .single_instr_loop_busy_i, .vector_fetch_o, .resume_o, .op_i, .alu_ccr_i,
  .condition_code_register_o, .trap_pc_i, .vector_addr_o, .return_addr_o, .resume_addr_o,
  .acc_a_o);
`default_nettype wire
